// ===== pkg/pipe_eq_defines.vh
// Constants for the PIPE-side clocking and per-lane equalization block.
// Assumes inclusion by bare name from every design file that needs them.
//
// How it works
// - PIPE clock 125/250/250/500 MHz per speed
// - Lane data 16 bits slow, 32 fast
// - Clock follows selected speed without synthesizer
// - Reference clock 100, 125 or 250 MHz
// - User clock 62.5, 125, 250 or 500
// - Stream clock mirrors core or user clock
// - Receive adapt: proposal step, then adaptation
// - Proposal: done high, adapt-done low
// - Adaptation: done and adapt-done together
// - Transmit command codes; one-cycle done pulse
// - Coefficient over three cycles: pre, main, post
// - Receive command codes; MAC returns to idle
`ifndef PIPE_EQ_DEFINES_VH
`define PIPE_EQ_DEFINES_VH

// Bus clock rate in MHz
`define CLK_MHZ 100

// PIPE clock per link speed, MHz
`define PCLK_SPEED1_MHZ 10'd125
`define PCLK_SPEED2_MHZ 10'd250
`define PCLK_SPEED3_MHZ 10'd250
`define PCLK_SPEED4_MHZ 10'd500
// Lane data width per speed
`define WIDTH_SLOW 6'd16
`define WIDTH_FAST 6'd32

// Transmit equalization commands
`define TXEQ_IDLE 2'b00
`define TXEQ_PRESET 2'b01
`define TXEQ_COEFF 2'b10
`define TXEQ_QUERY 2'b11
// Receive equalization commands
`define RXEQ_IDLE 2'b00
`define RXEQ_EQ 2'b10
`define RXEQ_BYPASS 2'b11

// Default transmit preset and highest defined preset
`define PRESET_DEFAULT 4'h4
`define PRESET_MAX 4'ha
// Adaptation time in ns and in bus clock cycles (longest time, rounded down)
`define ADAPT_NS 80
`define ADAPT_CYCLES ((`ADAPT_NS * `CLK_MHZ) / 1000)

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_LANE 12'h008

// Control field positions
`define CTRL_PROP_LSB 0
`define CTRL_STREAM_SEL 4
`define CTRL_REFCLK_LSB 8
`define CTRL_USERCLK_LSB 12
// Control reset value: proposal preset 4, core clock, 100 MHz ref, 250 MHz user
`define CTRL_RESET 32'h0000_2004

// Reference clock codes
`define REFCLK_100 2'h0
`define REFCLK_125 2'h1
`define REFCLK_250 2'h2
// User clock codes
`define USERCLK_62P5 2'h0
`define USERCLK_125 2'h1
`define USERCLK_250 2'h2
`define USERCLK_500 2'h3

`endif

// ===== rtl/lane_eq_engine.v
// One lane's transmit and receive equalization handshake engines.
// Assumes the MAC holds each command until it sees done, then returns it to idle.
`timescale 1ns/1ps
`include "pipe_eq_defines.vh"

module lane_eq_engine #(
	parameter ADAPT_CYCLES = `ADAPT_CYCLES
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Configuration
	input wire [3:0] proposal_preset,
	// Transmit equalization from MAC
	input wire [1:0] txeq_ctrl,
	input wire [3:0] txeq_preset,
	input wire [5:0] txeq_coeff,
	// Receive equalization from MAC
	input wire [1:0] rxeq_ctrl,
	input wire [3:0] rxeq_txpreset,
	// Transmit equalization answers
	output reg txeq_done,
	output reg [17:0] txeq_new_coeff,
	output reg [2:0] txeq_state,
	// Receive equalization answers
	output reg rxeq_done,
	output reg rxeq_adapt_done,
	output reg rxeq_preset_sel,
	output reg rxeq_lffs_sel,
	output reg [17:0] rxeq_new_txcoeff,
	output reg [2:0] rxeq_state
);
	// Transmit states
	localparam TX_IDLE = 3'd0;
	localparam TX_PRESET = 3'd1;
	localparam TX_COEFF = 3'd2;
	localparam TX_QUERY = 3'd4;
	localparam TX_DONE = 3'd5;
	// Receive states
	localparam RX_IDLE = 3'd0;
	localparam RX_PROPOSE = 3'd1;
	localparam RX_ADAPT = 3'd3;
	localparam RX_DONE = 3'd4;

	reg [1:0] coeff_step; // Which cursor comes next
	reg proposed; // Proposal step already made
	reg [7:0] adapt_cnt; // Adaptation timer

	// Preset to six-bit cursor triple; reserved presets fall back to default
	function [17:0] preset_coeff;
		input [3:0] p;
		reg [3:0] q;
		begin
			q = (p > `PRESET_MAX) ? `PRESET_DEFAULT : p;
			preset_coeff = {2'b00, q, 6'h30, 6'h00};
		end
	endfunction

	// Transmit engine: apply, collect or report, then one done pulse
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txeq_state <= TX_IDLE;
			txeq_done <= 1'b0;
			txeq_new_coeff <= {2'b00, `PRESET_DEFAULT, 6'h30, 6'h00};
			coeff_step <= 2'd0;
		end else begin
			txeq_done <= 1'b0;
			case (txeq_state)
				TX_IDLE: begin
					if (txeq_ctrl == `TXEQ_PRESET) begin
						txeq_state <= TX_PRESET;
					end else if (txeq_ctrl == `TXEQ_COEFF) begin
						// First cycle of the command carries the pre-cursor
						txeq_new_coeff[17:12] <= txeq_coeff;
						coeff_step <= 2'd1;
						txeq_state <= TX_COEFF;
					end else if (txeq_ctrl == `TXEQ_QUERY) begin
						txeq_state <= TX_QUERY;
					end
				end
				TX_PRESET: begin
					txeq_new_coeff <= preset_coeff(txeq_preset);
					txeq_done <= 1'b1;
					txeq_state <= TX_DONE;
				end
				TX_COEFF: begin
					if (coeff_step == 2'd1) begin
						txeq_new_coeff[11:6] <= txeq_coeff;
						coeff_step <= 2'd2;
					end else begin
						txeq_new_coeff[5:0] <= txeq_coeff;
						txeq_done <= 1'b1;
						txeq_state <= TX_DONE;
					end
				end
				TX_QUERY: begin
					// Query reports the coefficient now in force
					txeq_done <= 1'b1;
					txeq_state <= TX_DONE;
				end
				default: begin
					// Hold until the MAC drops the command
					if (txeq_ctrl == `TXEQ_IDLE) begin
						txeq_state <= TX_IDLE;
					end
				end
			endcase
		end
	end

	// Receive engine: proposal first, adaptation on the next request
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxeq_state <= RX_IDLE;
			rxeq_done <= 1'b0;
			rxeq_adapt_done <= 1'b0;
			rxeq_preset_sel <= 1'b0;
			rxeq_lffs_sel <= 1'b0;
			rxeq_new_txcoeff <= 18'h00000;
			proposed <= 1'b0;
			adapt_cnt <= 8'h00;
		end else begin
			rxeq_done <= 1'b0;
			rxeq_adapt_done <= 1'b0;
			rxeq_lffs_sel <= rxeq_ctrl[1];
			case (rxeq_state)
				RX_IDLE: begin
					if (rxeq_ctrl == `RXEQ_BYPASS) begin
						rxeq_done <= 1'b1;
						rxeq_adapt_done <= 1'b1;
						rxeq_state <= RX_DONE;
					end else if (rxeq_ctrl == `RXEQ_EQ && !proposed) begin
						rxeq_state <= RX_PROPOSE;
					end else if (rxeq_ctrl == `RXEQ_EQ) begin
						adapt_cnt <= ADAPT_CYCLES[7:0];
						rxeq_state <= RX_ADAPT;
					end
				end
				RX_PROPOSE: begin
					// Ask the partner for our preferred preset
					rxeq_new_txcoeff <= {14'h0000, proposal_preset};
					rxeq_preset_sel <= 1'b1;
					rxeq_done <= 1'b1;
					proposed <= 1'b1;
					rxeq_state <= RX_DONE;
				end
				RX_ADAPT: begin
					// Settle on the preset the partner now transmits
					if (adapt_cnt <= 8'h01) begin
						rxeq_new_txcoeff <= {14'h0000, rxeq_txpreset};
						rxeq_preset_sel <= 1'b1;
						rxeq_done <= 1'b1;
						rxeq_adapt_done <= 1'b1;
						proposed <= 1'b0;
						rxeq_state <= RX_DONE;
					end else begin
						adapt_cnt <= adapt_cnt - 8'h01;
					end
				end
				default: begin
					if (rxeq_ctrl == `RXEQ_IDLE) begin
						rxeq_state <= RX_IDLE;
					end
				end
			endcase
		end
	end
endmodule // lane_eq_engine

// ===== rtl/pipe_eq_phy.v
// PIPE-side clock control, speed tracking and per-lane equalization with an AHB-Lite slave.
// Assumes all MAC-facing inputs are synchronous to hclk and a single AHB-Lite master.
`timescale 1ns/1ps
`include "pipe_eq_defines.vh"

module pipe_eq_phy #(
	parameter LANES = 2,
	parameter ADAPT_CYCLES = `ADAPT_CYCLES
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Speed selection from MAC
	input wire [1:0] pipe_rate,
	// Clock control outputs
	output reg [9:0] pclk_mhz,
	output reg [5:0] lane_width,
	output reg [1:0] refclk_sel,
	output reg [1:0] userclk_sel,
	output reg stream_iface_clock_sel,
	// Transmit equalization, packed per lane
	input wire [2*LANES-1:0] txeq_ctrl,
	input wire [4*LANES-1:0] txeq_preset,
	input wire [6*LANES-1:0] txeq_coeff,
	output wire [LANES-1:0] txeq_done,
	output wire [18*LANES-1:0] txeq_new_coeff,
	output wire [3*LANES-1:0] txeq_state,
	// Receive equalization, packed per lane
	input wire [2*LANES-1:0] rxeq_ctrl,
	input wire [4*LANES-1:0] rxeq_txpreset,
	output wire [LANES-1:0] rxeq_done,
	output wire [LANES-1:0] rxeq_adapt_done,
	output wire [LANES-1:0] rxeq_preset_sel,
	output wire [LANES-1:0] rxeq_lffs_sel,
	output wire [18*LANES-1:0] rxeq_new_txcoeff,
	output wire [3*LANES-1:0] rxeq_state
);
	// Bus-side state and next values
	reg [31:0] ctrl; // Software control word
	reg [LANES-1:0] lane_adapted; // Sticky: lane finished receive adaptation
	reg [1:0] cur_rate; // Speed now in force
	reg wr_pend; // Write data phase pending
	reg [11:0] wr_addr; // Address captured for the write
	reg [31:0] next_rdata;
	reg [31:0] next_ctrl;

	// PIPE clock rate for a speed code
	function [9:0] rate_mhz;
		input [1:0] r;
		begin
			if (r == 2'd0) begin
				// First speed: slowest clock
				rate_mhz = `PCLK_SPEED1_MHZ;
			end else if (r == 2'd1) begin
				// Second speed
				rate_mhz = `PCLK_SPEED2_MHZ;
			end else if (r == 2'd2) begin
				// Third speed keeps the second speed's rate, width doubles instead
				rate_mhz = `PCLK_SPEED3_MHZ;
			end else begin
				// Fourth speed: fastest clock
				rate_mhz = `PCLK_SPEED4_MHZ;
			end
		end
	endfunction

	// Legal reference clock codes only
	function refclk_ok;
		input [1:0] c;
		begin
			// The fourth code names no reference rate
			refclk_ok = (c == `REFCLK_100) || (c == `REFCLK_125) || (c == `REFCLK_250);
		end
	endfunction

	// Speed tracking: clock rate and width follow the requested speed directly
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Come out of reset at the first speed
			cur_rate <= 2'd0;
			pclk_mhz <= `PCLK_SPEED1_MHZ;
			lane_width <= `WIDTH_SLOW;
		end else begin
			// Switching is a select change, not a synthesizer relock
			cur_rate <= pipe_rate;
			pclk_mhz <= rate_mhz(pipe_rate);
			// Top bit of the speed code picks the wide data path
			lane_width <= pipe_rate[1] ? `WIDTH_FAST : `WIDTH_SLOW;
		end
	end

	// Clock selections driven from the control word
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Reset selections match the control word's reset value
			refclk_sel <= `REFCLK_100;
			userclk_sel <= `USERCLK_250;
			stream_iface_clock_sel <= 1'b0;
		end else begin
			// Selections lag the control word by one edge
			refclk_sel <= ctrl[`CTRL_REFCLK_LSB+1:`CTRL_REFCLK_LSB];
			userclk_sel <= ctrl[`CTRL_USERCLK_LSB+1:`CTRL_USERCLK_LSB];
			// Stream clock is one of the two existing clocks, never a third one
			stream_iface_clock_sel <= ctrl[`CTRL_STREAM_SEL];
		end
	end

	// Control write; an illegal reference clock code keeps the old one
	always @* begin
		next_ctrl = ctrl;
		if (wr_pend && wr_addr == `REG_CTRL) begin
			// Proposal preset field
			next_ctrl[3:0] = hwdata[3:0];
			// Stream clock follows the core or the user clock
			next_ctrl[`CTRL_STREAM_SEL] = hwdata[`CTRL_STREAM_SEL];
			// All four user clock codes are legal
			next_ctrl[`CTRL_USERCLK_LSB+1:`CTRL_USERCLK_LSB] = hwdata[`CTRL_USERCLK_LSB+1:`CTRL_USERCLK_LSB];
			// Keeps a bad code from selecting a reference that does not exist
			if (refclk_ok(hwdata[`CTRL_REFCLK_LSB+1:`CTRL_REFCLK_LSB])) begin
				next_ctrl[`CTRL_REFCLK_LSB+1:`CTRL_REFCLK_LSB] = hwdata[`CTRL_REFCLK_LSB+1:`CTRL_REFCLK_LSB];
			end
		end
	end

	// Read mux, evaluated in the address phase
	always @* begin
		// Unmapped offsets fall through and read as zero
		next_rdata = 32'h0000_0000;
		if (haddr == `REG_CTRL) begin
			// Control word reads back as stored
			next_rdata = ctrl;
		end else if (haddr == `REG_STATUS) begin
			// Width, rate in MHz and speed code
			next_rdata = {10'h000, lane_width, pclk_mhz, 4'h0, cur_rate};
		end else if (haddr == `REG_LANE) begin
			// One flag per lane, upper bits zero
			next_rdata[LANES-1:0] = lane_adapted;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY, unmapped reads as zero
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Ready, OKAY and nothing pending out of reset
			ctrl <= `CTRL_RESET;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			// Write data arrive one cycle after their address phase
			ctrl <= next_ctrl;
			wr_pend <= 1'b0;
			if (hsel && hready && htrans[1]) begin
				// Only full-word accesses are expected; hsize is not checked
				wr_pend <= hwrite;
				wr_addr <= haddr;
				// Registered here so hrdata stands through the data phase
				if (!hwrite) begin
					hrdata <= next_rdata;
				end
			end
		end
	end

	// Sticky adaptation flags: a new completion wins over a software clear
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lane_adapted <= {LANES{1'b0}};
		end else begin
			if (wr_pend && wr_addr == `REG_LANE) begin
				// Write one to clear; a completion in the same cycle stays set
				lane_adapted <= (lane_adapted & ~hwdata[LANES-1:0]) | (rxeq_done & rxeq_adapt_done);
			end else begin
				// No write: only new completions are added
				lane_adapted <= lane_adapted | (rxeq_done & rxeq_adapt_done);
			end
		end
	end

	// One independent engine per lane
	genvar i;
	generate
		for (i = 0; i < LANES; i = i + 1) begin : g_lane
			// Each lane takes its own slice of the packed buses
			lane_eq_engine #(
				.ADAPT_CYCLES(ADAPT_CYCLES)
			) u_eq (
				.hclk(hclk),
				.hresetn(hresetn),
				.proposal_preset(ctrl[3:0]),
				.txeq_ctrl(txeq_ctrl[2*i+1:2*i]),
				.txeq_preset(txeq_preset[4*i+3:4*i]),
				.txeq_coeff(txeq_coeff[6*i+5:6*i]),
				.rxeq_ctrl(rxeq_ctrl[2*i+1:2*i]),
				.rxeq_txpreset(rxeq_txpreset[4*i+3:4*i]),
				.txeq_done(txeq_done[i]),
				.txeq_new_coeff(txeq_new_coeff[18*i+17:18*i]),
				.txeq_state(txeq_state[3*i+2:3*i]),
				.rxeq_done(rxeq_done[i]),
				.rxeq_adapt_done(rxeq_adapt_done[i]),
				.rxeq_preset_sel(rxeq_preset_sel[i]),
				.rxeq_lffs_sel(rxeq_lffs_sel[i]),
				.rxeq_new_txcoeff(rxeq_new_txcoeff[18*i+17:18*i]),
				.rxeq_state(rxeq_state[3*i+2:3*i])
			);
		end
	endgenerate
endmodule // pipe_eq_phy

// ===== verification/mac_eq_lane.sv
// Model of one MAC lane driving the equalization handshakes.
// Assumes its tasks are called just after a rising edge of hclk.
`timescale 1ns/1ps
// Commands only: lane deskew, idle inference and SKP length stay with the MAC
module mac_eq_lane (
	// Clock
	input wire hclk,
	// Answers from the lane
	input wire tx_done,
	input wire rx_done,
	input wire rx_adapt,
	// Commands to the lane
	output logic [1:0] tx_ctrl = 2'b00,
	output logic [3:0] tx_preset = 4'h0,
	output logic [5:0] tx_coeff = 6'h00,
	output logic [1:0] rx_ctrl = 2'b00,
	output logic [3:0] rx_txpreset = 4'h0
);
	// Hold the command until done, coefficient as pre, main, post
	task automatic tx(input logic [1:0] cmd, input logic [3:0] p, input logic [17:0] c);
		int n;
		n = 0;
		tx_ctrl <= cmd;
		tx_preset <= p;
		tx_coeff <= c[17:12];
		do begin
			@(posedge hclk);
			n++;
			tx_coeff <= (n == 1) ? c[11:6] : (n == 2) ? c[5:0] : ~tx_coeff;
		end while (tx_done !== 1'b1);
		// Back to idle; released lines no longer show the old value
		tx_ctrl <= 2'b00;
		tx_preset <= ~p;
		@(posedge hclk);
	endtask
	// Receive request held until done, then idle again
	task automatic rx(input logic [1:0] cmd, input logic [3:0] tp, output logic ad);
		rx_ctrl <= cmd;
		rx_txpreset <= tp;
		do @(posedge hclk); while (rx_done !== 1'b1);
		ad = rx_adapt;
		rx_ctrl <= 2'b00;
		rx_txpreset <= ~tp;
		@(posedge hclk);
	endtask
endmodule // mac_eq_lane

// ===== verification/pcie_pipe_eq_sequencing_clocking_test.sv
// Self-checking bench for the PIPE clocking and lane equalization block.
// Assumes the lane model and the checker are compiled before it.
`timescale 1ns/1ps
module pcie_pipe_eq_sequencing_clocking_test;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ad;
	logic [11:0] haddr = 0;
	logic [1:0] htrans = 0, pipe_rate = 0;
	logic [31:0] hwdata = 0, rd;
	wire [31:0] hrdata;
	wire hreadyout, hresp, sclk_sel;
	wire [9:0] pclk_mhz;
	wire [5:0] lane_width, txs, rxs;
	wire [1:0] refclk_sel, userclk_sel, txd, rxd, rxa, psel, lffs;
	wire [3:0] txc, rxc;
	wire [7:0] txp, rxp;
	wire [11:0] txk;
	wire [35:0] ncoef, ntx;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	// Rows: command, preset, coefficient, expected coefficient
	typedef struct packed {logic [1:0] cmd; logic [3:0] p; logic [17:0] c; logic [17:0] e;} row_t;
	row_t rows [6] = '{'{2'b01, 4'h5, 18'h0, 18'h05c00}, '{2'b11, 4'h0, 18'h0, 18'h05c00},
		'{2'b01, 4'ha, 18'h0, 18'h0ac00}, '{2'b01, 4'hb, 18'h0, 18'h04c00},
		'{2'b10, 4'h0, 18'h2b5c3, 18'h2b5c3}, '{2'b11, 4'h0, 18'h0, 18'h2b5c3}};
	logic [9:0] mhz [4] = '{10'd125, 10'd250, 10'd250, 10'd500};
	pipe_eq_phy #(.LANES(2), .ADAPT_CYCLES(2)) u_pipe_eq_phy (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pipe_rate, .pclk_mhz,
		.lane_width, .refclk_sel, .userclk_sel, .stream_iface_clock_sel(sclk_sel), .txeq_ctrl(txc),
		.txeq_preset(txp), .txeq_coeff(txk), .txeq_done(txd), .txeq_new_coeff(ncoef), .txeq_state(txs),
		.rxeq_ctrl(rxc), .rxeq_txpreset(rxp), .rxeq_done(rxd), .rxeq_adapt_done(rxa), .rxeq_preset_sel(psel),
		.rxeq_lffs_sel(lffs), .rxeq_new_txcoeff(ntx), .rxeq_state(rxs));
	mac_eq_lane u_mac0 (.hclk, .tx_done(txd[0]), .rx_done(rxd[0]), .rx_adapt(rxa[0]), .tx_ctrl(txc[1:0]),
		.tx_preset(txp[3:0]), .tx_coeff(txk[5:0]), .rx_ctrl(rxc[1:0]), .rx_txpreset(rxp[3:0]));
	mac_eq_lane u_mac1 (.hclk, .tx_done(txd[1]), .rx_done(rxd[1]), .rx_adapt(rxa[1]), .tx_ctrl(txc[3:2]),
		.tx_preset(txp[7:4]), .tx_coeff(txk[11:6]), .rx_ctrl(rxc[3:2]), .rx_txpreset(rxp[7:4]));
	initial forever #5 hclk = ~hclk;
	// Cuts a hang short
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			results;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One single word transfer: address phase, then data phase
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic results;
		$display("errors %0d, checks %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		chk(pclk_mhz, 125);
		chk(ncoef[17:0], 18'h04c00);
		hresetn <= 1;
		@(posedge hclk);
		// Preset apply, query, reserved preset and coefficient command, as before a rate change
		for (int i = 0; i < 6; i++) begin
			u_mac0.tx(rows[i].cmd, rows[i].p, rows[i].c);
			chk(ncoef[17:0], rows[i].e);
		end
		for (int r = 0; r < 4; r++) begin
			pipe_rate <= r[1:0];
			repeat (2) @(posedge hclk);
			chk(pclk_mhz, mhz[r]);
			chk(lane_width, r < 2 ? 16 : 32);
			chk({lffs, txs, rxs}, 14'h0000);
			ahb(0, 12'h004, 0, rd);
			chk({hreadyout, hresp}, 2'b10);
			chk(rd[21:0], {r < 2 ? 6'd16 : 6'd32, mhz[r], 4'h0, r[1:0]});
		end
		ahb(0, 12'h000, 0, rd);
		chk(rd, 32'h00002004);
		ahb(0, 12'h00c, 0, rd);
		chk(rd, 0);
		ahb(1, 12'h000, 32'h00002204, rd);
		ahb(1, 12'h000, 32'h00001316, rd);
		repeat (2) @(posedge hclk);
		chk(refclk_sel, 2);
		chk(userclk_sel, 1);
		chk(sclk_sel, 1);
		ahb(0, 12'h000, 0, rd);
		chk(rd, 32'h00001216);
		u_mac0.rx(2'b11, 4'h0, ad);
		chk(ad, 1);
		chk(lffs[0], 1);
		u_mac0.rx(2'b10, 4'h0, ad);
		chk(ad, 0);
		chk(ntx[3:0], 4'h6);
		chk(psel[0], 1);
		chk(rxs[2:0], 3'h4);
		u_mac0.rx(2'b10, 4'h7, ad);
		chk(ad, 1);
		chk(ntx[3:0], 4'h7);
		ahb(0, 12'h008, 0, rd);
		chk(rd[1:0], 2'b01);
		ahb(1, 12'h008, 1, rd);
		ahb(0, 12'h008, 0, rd);
		chk(rd[1:0], 0);
		// Lane 1 answers while lane 0 is busy proposing
		fork
			u_mac0.rx(2'b10, 4'h0, ad);
			u_mac1.tx(2'b01, 4'h3, 18'h0);
		join
		chk(ncoef[35:18], 18'h03c00);
		chk(ncoef[17:0], 18'h2b5c3);
		chk(ntx[3:0], 4'h6);
		u_mac1.rx(2'b11, 4'h0, ad);
		chk(ad, 1);
		ahb(0, 12'h008, 0, rd);
		chk(rd[1:0], 2'b10);
		pipe_rate <= 2'd3;
		repeat (2) @(posedge hclk);
		hresetn <= 0;
		@(posedge hclk);
		chk(pclk_mhz, 125);
		hresetn <= 1;
		pipe_rate <= 2'd0;
		@(posedge hclk);
		ahb(0, 12'h000, 0, rd);
		chk(rd, 32'h00002004);
		results;
	end
endmodule // pcie_pipe_eq_sequencing_clocking_test

// ===== verification/pipe_eq_phy_props.sv
// Checker for the speed outputs and lane 0 equalization handshakes.
// Assumes it is bound onto pipe_eq_phy and sees only its ports.
`timescale 1ns/1ps
module pipe_eq_phy_props #(
	parameter LANES = 2
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Speed
	input wire [1:0] pipe_rate,
	input wire [9:0] pclk_mhz,
	input wire [5:0] lane_width,
	// Lane handshakes
	input wire [2*LANES-1:0] txeq_ctrl,
	input wire [LANES-1:0] txeq_done,
	input wire [3*LANES-1:0] txeq_state,
	input wire [2*LANES-1:0] rxeq_ctrl,
	input wire [LANES-1:0] rxeq_done,
	input wire [LANES-1:0] rxeq_adapt_done,
	input wire [LANES-1:0] rxeq_lffs_sel,
	input wire [3*LANES-1:0] rxeq_state
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Lane 0 idle; the transmit side must also be offered a command
	wire tx_take = txeq_state[2:0] == 3'd0 && txeq_ctrl[1:0] != 2'b00;
	wire rx_take = rxeq_state[2:0] == 3'd0;
	a_pclk_rate: assert property (
		$past(hresetn) |-> pclk_mhz == ($past(pipe_rate) == 2'd0 ? 10'd125 :
		$past(pipe_rate) == 2'd3 ? 10'd500 : 10'd250)) else $error("pipe clock rate wrong");
	a_lane_width: assert property (
		$past(hresetn) |-> lane_width == ($past(pipe_rate[1]) ? 6'd32 : 6'd16)) else $error("lane width wrong");
	a_tx_preset_lat: assert property (
		tx_take && txeq_ctrl[0] |=> !txeq_done[0] ##1 txeq_done[0]) else $error("preset done late");
	a_tx_coeff_lat: assert property (
		tx_take && txeq_ctrl[1:0] == 2'b10 |=> !txeq_done[0] [*2] ##1 txeq_done[0]) else $error("coeff done late");
	a_tx_done_pulse: assert property (
		txeq_done[0] |=> !txeq_done[0]) else $error("tx done too long");
	a_rx_bypass: assert property (
		rx_take && rxeq_ctrl[1:0] == 2'b11 |=> rxeq_done[0] && rxeq_adapt_done[0]) else $error("bypass late");
	a_rx_eq_wait: assert property (
		rx_take && rxeq_ctrl[1:0] == 2'b10 |=> !rxeq_done[0] ##[1:11] rxeq_done[0]) else $error("rx done late");
	a_rx_adapt_pair: assert property (
		rxeq_adapt_done[0] |-> rxeq_done[0]) else $error("adapt without done");
	a_rx_done_pulse: assert property (
		rxeq_done[0] |=> !rxeq_done[0]) else $error("rx done too long");
	a_lffs_follow: assert property (
		$past(hresetn) |-> rxeq_lffs_sel[0] == $past(rxeq_ctrl[1])) else $error("lffs select wrong");
	// Main scenarios reached
	c_tx_coeff: cover property (tx_take && txeq_ctrl[1:0] == 2'b10);
	c_rx_adapted: cover property (rxeq_done[0] && rxeq_adapt_done[0]);
	c_rx_proposal: cover property (rxeq_done[0] && !rxeq_adapt_done[0]);
endmodule // pipe_eq_phy_props

bind pipe_eq_phy pipe_eq_phy_props #(.LANES(LANES)) u_props (.hclk, .hresetn, .pipe_rate, .pclk_mhz,
	.lane_width, .txeq_ctrl, .txeq_done, .txeq_state, .rxeq_ctrl, .rxeq_done, .rxeq_adapt_done,
	.rxeq_lffs_sel, .rxeq_state);
